// [verilog/tefs_pkg.sv]
// Purpose: Shared constants of the timer event flag and software event block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Offsets are byte addresses; masks mark implemented bits
package tefs_pkg;
   // Register byte offsets
   localparam logic [11:0] TEFS_OFF_CTRL = 12'h000;
   localparam logic [11:0] TEFS_OFF_SLAVE = 12'h008;
   localparam logic [11:0] TEFS_OFF_IRQEN = 12'h00C;
   localparam logic [11:0] TEFS_OFF_FLAGS = 12'h010;
   localparam logic [11:0] TEFS_OFF_SWEVG = 12'h014;
   localparam logic [11:0] TEFS_OFF_CHMODE = 12'h018;
   localparam logic [11:0] TEFS_OFF_CAPA = 12'h034;
   localparam logic [11:0] TEFS_OFF_CAPB = 12'h038;
   // Bit positions of the flags; all but the over-capture bits also serve strobes and enables
   localparam int TEFS_B_UP = 0;
   localparam int TEFS_B_CHA = 1;
   localparam int TEFS_B_CHB = 2;
   localparam int TEFS_B_TRG = 6;
   localparam int TEFS_B_OVA = 9;
   localparam int TEFS_B_OVB = 10;
   // Control bits
   localparam int TEFS_B_SUPPRESS = 1;
   localparam int TEFS_B_UPSRC = 2;
   // Channel mode fields (two bits each)
   localparam int TEFS_MS_A_LO = 0;
   localparam int TEFS_MS_B_LO = 8;
   localparam logic [1:0] TEFS_MS_OUTPUT = 2'h0;
   // Slave mode field and pause code
   localparam logic [2:0] TEFS_SMC_PAUSE = 3'h5;
   // Implemented-bit masks
   localparam logic [31:0] TEFS_FLAGS_MASK = 32'h0000_0647;
   localparam logic [31:0] TEFS_GEN_MASK = 32'h0000_0047;
   localparam logic [31:0] TEFS_CTRL_MASK = 32'h0000_0006;
   localparam logic [31:0] TEFS_SLAVE_MASK = 32'h0000_0007;
   localparam logic [31:0] TEFS_CHMODE_MASK = 32'h0000_FFFF;
   // Reset value of every register
   localparam logic [31:0] TEFS_RST_WORD = 32'h0000_0000;
   // Counter and capture width
   localparam int TEFS_CNT_W = 16;
endpackage

// [verilog/tefs_timer_flags.sv]
// Purpose: Event flags, software event strobes and capture side effects of a
//    two-channel timer, reached over APB
// Assumes: All event inputs are one-cycle pulses synchronous to mclk_in;
//    trigger input is a synchronous level
// Notes: Registered APB answer, no wait state on any access
//
// How it works
// (R01) Channel A recapture with flag set: over-capture
// (R02) Channel B over-capture works like channel A
// (R03) Trigger edges set trigger flag; pause: both
// (R04) Capture or compare match sets channel A flag
// (R05) Reading channel A capture clears flag (input)
// (R06) Update event sets update flag
// (R07) Flags cleared by writing zero; channel flags also by capture read
// (R08) Trigger strobe sets trigger flag, self-clears
// (R09) Channel A strobe sets flag, self-clears
// (R10) Channel A strobe in input captures counter
// (R11) Channel B strobe works like channel A
// (R12) Update strobe clears counter and prescaler
// (R13) Update strobe produces an update event
// (R14) Channel B flag follows channel A rules
// (R15) Interrupt only where enable bit is set
// (R16) Suppress blocks update event, still clears counter
// (R17) Source select: only overflow raises update flag
// (R18) Hardware set beats software clear
// (R19) Reserved bits read zero, ignore writes
`timescale 1ns/1ns
`default_nettype none
module tefs_timer_flags
   import tefs_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic overflow_in,
   input wire logic trigger_in,
   input wire logic cap_a_in,
   input wire logic cap_b_in,
   input wire logic cmp_a_in,
   input wire logic cmp_b_in,
   input wire logic [15:0] counter_in,
   output logic update_event_out,
   output logic counter_clear_out,
   output logic trigger_event_out,
   output logic chan_a_event_out,
   output logic chan_b_event_out,
   output logic irq_out
);
   // Bus answer registers
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   // Software-held configuration
   logic [31:0] ctrl_ff;
   logic [31:0] slave_ff;
   logic [31:0] irqen_ff;
   logic [31:0] chmode_ff;
   // Flags word, only implemented bits ever set
   logic [31:0] flags_ff;
   logic [31:0] nxt_flags;
   // Self-clearing strobes, high one cycle after the write
   logic trigger_gen_strobe_ff;
   logic update_gen_strobe_ff;
   logic [1:0] chan_strobe_ff;
   // Trigger input history for edge detection
   logic trig_d_ff;
   // Captured counter values per channel
   logic [TEFS_CNT_W-1:0] cap_val_ff [2];
   // Registered event outputs
   logic update_event_ff;
   logic counter_clear_ff;
   logic trigger_event_ff;
   logic [1:0] chan_event_ff;
   logic irq_ff;
   // Decoded access strobes
   logic acc_done;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic [31:0] rd_word;
   // Event terms
   logic trig_rise;
   logic trig_fall;
   logic pause_mode;
   logic trig_event;
   logic update_event;
   logic update_flag_set;
   logic suppress;
   logic upsrc;
   logic [1:0] in_mode;
   logic [1:0] hw_cap;
   logic [1:0] hw_cmp;
   logic [1:0] cap_event;
   logic [1:0] chan_set;
   logic [1:0] cap_read;
   logic [1:0] ov_set;
   logic [31:0] hw_set;
   logic [31:0] sw_clr;

   // Access completes at the edge where the master sees pready
   assign acc_done = psel_in & penable_in & pready_ff;
   assign wr_en = acc_done & pwrite_in;
   assign rd_en = acc_done & ~pwrite_in;

   // Register map decode, word aligned only
   always_comb begin
      addr_ok = 1'b1;
      rd_word = TEFS_RST_WORD;
      if (paddr_in[1:0] != 2'h0) begin
         // Misaligned: refused
         addr_ok = 1'b0;
      end else begin
         unique case (paddr_in)
            TEFS_OFF_CTRL: rd_word = ctrl_ff;
            TEFS_OFF_SLAVE: rd_word = slave_ff;
            TEFS_OFF_IRQEN: rd_word = irqen_ff;
            TEFS_OFF_FLAGS: rd_word = flags_ff & TEFS_FLAGS_MASK; // see (R19)
            // Strobes are write-only in effect and read back as zero
            TEFS_OFF_SWEVG: rd_word = TEFS_RST_WORD;
            TEFS_OFF_CHMODE: rd_word = chmode_ff;
            TEFS_OFF_CAPA: rd_word = {16'h0000, cap_val_ff[0]};
            TEFS_OFF_CAPB: rd_word = {16'h0000, cap_val_ff[1]};
            default: addr_ok = 1'b0;
         endcase
      end
   end

   // APB answer: ready one cycle after setup, data and error with it
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         // Setup cycle seen: answer in the access cycle
         pready_ff <= psel_in & ~penable_in;
         pslverr_ff <= psel_in & ~penable_in & ~addr_ok;
         if (psel_in & ~penable_in & ~pwrite_in) begin
            prdata_ff <= rd_word;
         end else begin
            prdata_ff <= 32'h0000_0000;
         end
      end
   end

   // Plain configuration registers, reserved bits dropped on write
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_ff <= TEFS_RST_WORD;
         slave_ff <= TEFS_RST_WORD;
         irqen_ff <= TEFS_RST_WORD;
         chmode_ff <= TEFS_RST_WORD;
      end else if (wr_en) begin
         if (paddr_in == TEFS_OFF_CTRL) begin
            ctrl_ff <= pwdata_in & TEFS_CTRL_MASK;
         end
         if (paddr_in == TEFS_OFF_SLAVE) begin
            slave_ff <= pwdata_in & TEFS_SLAVE_MASK;
         end
         if (paddr_in == TEFS_OFF_IRQEN) begin
            irqen_ff <= pwdata_in & TEFS_GEN_MASK;
         end
         if (paddr_in == TEFS_OFF_CHMODE) begin
            chmode_ff <= pwdata_in & TEFS_CHMODE_MASK;
         end
      end
   end

   // Strobes live one cycle, so hardware clears them by itself
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         trigger_gen_strobe_ff <= 1'b0;
         update_gen_strobe_ff <= 1'b0;
         chan_strobe_ff <= 2'h0;
      end else begin
         if (wr_en && paddr_in == TEFS_OFF_SWEVG) begin
            trigger_gen_strobe_ff <= pwdata_in[TEFS_B_TRG]; // see (R08)
            update_gen_strobe_ff <= pwdata_in[TEFS_B_UP]; // see (R12)
            chan_strobe_ff <= {pwdata_in[TEFS_B_CHB], pwdata_in[TEFS_B_CHA]}; // see (R09)
         end else begin
            trigger_gen_strobe_ff <= 1'b0;
            update_gen_strobe_ff <= 1'b0;
            chan_strobe_ff <= 2'h0;
         end
      end
   end

   // Trigger edge history
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         trig_d_ff <= 1'b0;
      end else begin
         trig_d_ff <= trigger_in;
      end
   end

   // Trigger: rising edge is active; pause adds the falling edge
   assign trig_rise = trigger_in & ~trig_d_ff;
   assign trig_fall = ~trigger_in & trig_d_ff;
   assign pause_mode = (slave_ff[2:0] == TEFS_SMC_PAUSE);
   assign trig_event = trig_rise | (pause_mode & trig_fall) | trigger_gen_strobe_ff; // see (R03)

   // Update: suppress blocks the event, the counter clear still goes out
   assign suppress = ctrl_ff[TEFS_B_SUPPRESS];
   assign upsrc = ctrl_ff[TEFS_B_UPSRC];
   assign update_event = (overflow_in | update_gen_strobe_ff) & ~suppress; // see (R13) (R16)
   // With source select set, a software update leaves the flag alone
   assign update_flag_set = ~suppress & (overflow_in | (update_gen_strobe_ff & ~upsrc)); // see (R17)

   // Per-channel inputs gathered into vectors
   assign in_mode[0] = chmode_ff[TEFS_MS_A_LO +: 2] != TEFS_MS_OUTPUT;
   assign in_mode[1] = chmode_ff[TEFS_MS_B_LO +: 2] != TEFS_MS_OUTPUT;
   assign hw_cap = {cap_b_in, cap_a_in};
   assign hw_cmp = {cmp_b_in, cmp_a_in};
   assign cap_read[0] = rd_en && paddr_in == TEFS_OFF_CAPA;
   assign cap_read[1] = rd_en && paddr_in == TEFS_OFF_CAPB;

   // Channel logic, identical for both channels
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         // Capture from the pin or from the software strobe in input mode
         assign cap_event[ch] = in_mode[ch] & (hw_cap[ch] | chan_strobe_ff[ch]); // see (R10) (R11)
         // Compare only counts in output mode; strobe sets in either mode
         assign chan_set[ch] = cap_event[ch] | (~in_mode[ch] & hw_cmp[ch])
                             | chan_strobe_ff[ch]; // see (R04) (R14)
         // Recapture while the flag is still up is an over-capture
         assign ov_set[ch] = cap_event[ch] & flags_ff[TEFS_B_CHA + ch]; // see (R01) (R02)

         // Capture value register takes the counter on a capture
         always_ff @(posedge mclk_in or posedge rst_in) begin
            if (rst_in) begin
               cap_val_ff[ch] <= 16'h0000;
            end else if (cap_event[ch]) begin
               cap_val_ff[ch] <= counter_in;
            end
         end
      end
   endgenerate

   // Set and clear vectors for the flags word
   always_comb begin
      hw_set = 32'h0000_0000;
      hw_set[TEFS_B_UP] = update_flag_set; // see (R06)
      hw_set[TEFS_B_TRG] = trig_event; // see (R03) (R08)
      hw_set[TEFS_B_CHA] = chan_set[0]; // see (R09)
      hw_set[TEFS_B_CHB] = chan_set[1]; // see (R14)
      hw_set[TEFS_B_OVA] = ov_set[0];
      hw_set[TEFS_B_OVB] = ov_set[1];
      sw_clr = 32'h0000_0000;
      // Writing zero clears, writing one leaves the bit as it is
      if (wr_en && paddr_in == TEFS_OFF_FLAGS) begin
         sw_clr = ~pwdata_in & TEFS_FLAGS_MASK; // see (R07)
      end
      // Capture read clears the capture flag in input mode
      sw_clr[TEFS_B_CHA] = sw_clr[TEFS_B_CHA] | (cap_read[0] & in_mode[0]); // see (R05)
      sw_clr[TEFS_B_CHB] = sw_clr[TEFS_B_CHB] | (cap_read[1] & in_mode[1]); // see (R14)
      // Set wins over clear so no event goes missing
      nxt_flags = ((flags_ff & ~sw_clr) | hw_set) & TEFS_FLAGS_MASK; // see (R18) (R19)
   end

   // Flags word
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         flags_ff <= TEFS_RST_WORD;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   // Registered event outputs toward the rest of the timer
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         update_event_ff <= 1'b0;
         counter_clear_ff <= 1'b0;
         trigger_event_ff <= 1'b0;
         chan_event_ff <= 2'h0;
      end else begin
         update_event_ff <= update_event;
         // Counter and prescaler clear on every update strobe, suppressed or not
         counter_clear_ff <= update_gen_strobe_ff; // see (R12) (R16)
         trigger_event_ff <= trig_event;
         chan_event_ff <= chan_set;
      end
   end

   // Level interrupt: any enabled flag; over-capture has no enable
   // Built from the stored flags, so it trails them by one cycle
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(flags_ff & irqen_ff & TEFS_GEN_MASK); // see (R15)
      end
   end

   // Ports come straight from flip-flops
   assign prdata_out = prdata_ff;
   assign pready_out = pready_ff;
   assign pslverr_out = pslverr_ff;
   assign update_event_out = update_event_ff;
   assign counter_clear_out = counter_clear_ff;
   assign trigger_event_out = trigger_event_ff;
   assign chan_a_event_out = chan_event_ff[0];
   assign chan_b_event_out = chan_event_ff[1];
   assign irq_out = irq_ff;

   // Checks, all in the one clock domain
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);

   a_ova_on_recapture: assert property ( // see (R01)
      (in_mode[0] && cap_a_in && flags_ff[TEFS_B_CHA]) |=> flags_ff[TEFS_B_OVA])
      else $error("over-capture A not set");
   a_ovb_on_recapture: assert property ( // see (R02)
      (in_mode[1] && cap_b_in && flags_ff[TEFS_B_CHB]) |=> flags_ff[TEFS_B_OVB])
      else $error("over-capture B not set");
   a_trig_pause_fall: assert property ( // see (R03)
      (pause_mode && $fell(trigger_in)) |=> flags_ff[TEFS_B_TRG])
      else $error("pause falling edge missed");
   a_cha_cmp_sets: assert property ( // see (R04)
      (!in_mode[0] && cmp_a_in) |=> flags_ff[TEFS_B_CHA] && chan_a_event_out)
      else $error("compare match did not flag");
   a_cap_read_clear: assert property ( // see (R05)
      (cap_read[0] && in_mode[0] && !hw_set[TEFS_B_CHA]) |=> !flags_ff[TEFS_B_CHA])
      else $error("capture read did not clear");
   a_flag_no_self_clear: assert property ( // see (R07)
      (flags_ff[TEFS_B_TRG] && !(wr_en && paddr_in == TEFS_OFF_FLAGS)) |=> flags_ff[TEFS_B_TRG])
      else $error("trigger flag dropped by itself");
   a_swupd_sequence: assert property ( // see (R12)
      (wr_en && paddr_in == TEFS_OFF_SWEVG && pwdata_in[TEFS_B_UP])
      |=> update_gen_strobe_ff ##1 (counter_clear_out && !update_gen_strobe_ff))
      else $error("update strobe sequence wrong");
   a_cha_capture_value: assert property ( // see (R10)
      (chan_strobe_ff[0] && in_mode[0]) |=> cap_val_ff[0] == $past(counter_in))
      else $error("strobe capture value wrong");
   a_suppress_blocks: assert property ( // see (R16)
      suppress |=> !update_event_out)
      else $error("update event while suppressed");
   a_upsrc_no_flag: assert property ( // see (R17)
      (update_gen_strobe_ff && upsrc && !overflow_in && !flags_ff[TEFS_B_UP]
       && !suppress) |=> !flags_ff[TEFS_B_UP] && update_event_out)
      else $error("software update raised flag");
   a_set_beats_clear: assert property ( // see (R18)
      (hw_set[TEFS_B_UP] && sw_clr[TEFS_B_UP]) |=> flags_ff[TEFS_B_UP])
      else $error("set lost against clear");
   a_irq_tracks_flags: assert property ( // see (R15)
      (|(flags_ff & irqen_ff & TEFS_GEN_MASK)) |=> irq_out)
      else $error("irq missing for enabled flag");
   a_irq_quiet_masked: assert property ( // see (R15)
      !(|(flags_ff & irqen_ff & TEFS_GEN_MASK)) |=> !irq_out)
      else $error("irq raised without enabled flag");
   a_reserved_zero: assert property ( // see (R19)
      (flags_ff & ~TEFS_FLAGS_MASK) == 32'h0000_0000)
      else $error("reserved flag bit set");

   c_over_capture: cover property (flags_ff[TEFS_B_OVA] && flags_ff[TEFS_B_OVB]);
   c_pause_trigger: cover property (pause_mode && trig_fall);
   c_set_vs_clear: cover property (hw_set[TEFS_B_CHA] && sw_clr[TEFS_B_CHA]);
   c_irq_raised: cover property ($rose(irq_out));
   // Software capture on channel B while its flag is already up
   c_sw_overcapture: cover property (chan_strobe_ff[1] && in_mode[1] && flags_ff[TEFS_B_CHB]);
endmodule
`default_nettype wire

// [sim/timer_event_flags_swgen_tb.sv]
// Purpose: Self-checking bench for the timer event flag and software event block
// Assumes: No wait state on any APB access, event inputs are one-cycle pulses
// Notes: Output pulses are counted by monitors so that checks never race an edge
`timescale 1ns/1ns
`default_nettype none
module timer_event_flags_swgen_tb;
   import tefs_pkg::*;
   logic mclk_in = 1'b0; // Bench clock, 50 ns period
   logic rst_in = 1'b1; // Async reset, high at start
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, irq, upd_ev, clr_ev, trg_ev, cha_ev, chb_ev;
   logic [4:0] ev = 5'h00; // Pulses: cmp_b, cmp_a, cap_b, cap_a, overflow
   logic trg = 1'b0; // Trigger level
   logic [15:0] cnt = 16'h0000; // Counter value seen by captures
   int fails = 0, checks_done = 0;
   int n_upd = 0, n_clr = 0, n_trg = 0, n_cha = 0, n_chb = 0; // Output pulse tallies
   int u, c, t, bp, ov;
   logic [11:0] cap_addr;
   always #25 mclk_in = ~mclk_in;
   tefs_timer_flags tefs_timer_flags_inst (.mclk_in(mclk_in), .rst_in(rst_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .overflow_in(ev[0]), .trigger_in(trg), .cap_a_in(ev[1]),
      .cap_b_in(ev[2]), .cmp_a_in(ev[3]), .cmp_b_in(ev[4]), .counter_in(cnt),
      .update_event_out(upd_ev), .counter_clear_out(clr_ev),
      .trigger_event_out(trg_ev), .chan_a_event_out(cha_ev), .chan_b_event_out(chb_ev),
      .irq_out(irq));
   // Pulse monitors; a missed or doubled pulse shows in the tallies
   always @(posedge mclk_in) begin
      if (upd_ev === 1'b1) n_upd++;
      if (clr_ev === 1'b1) n_clr++;
      if (trg_ev === 1'b1) n_trg++;
      if (cha_ev === 1'b1) n_cha++;
      if (chb_ev === 1'b1) n_chb++;
   end
   // Verdict and end of run, shared by tests and watchdog
   task end_sim();
      $display("Checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Single comparison point
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task idle(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   // One APB transfer; waits for pready as long as it takes, the watchdog bounds it
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
      @(posedge mclk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_in);
      penable <= 1'b1;
      do begin
         @(posedge mclk_in);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, exp);
   endtask
   // Strobe a set of event inputs for one cycle, then let flags settle
   task pulse(input logic [4:0] m);
      @(posedge mclk_in);
      ev <= m;
      @(posedge mclk_in);
      ev <= 5'h00;
      idle(3);
   endtask
   task set_trg(input logic v);
      @(posedge mclk_in);
      trg <= v;
      idle(3);
   endtask
   // Watchdog; the full sequence needs well under 2000 cycles
   initial begin
      repeat (8000) @(posedge mclk_in);
      fails++;
      end_sim();
   end
   initial begin
      logic [31:0] r;
      logic e;
      repeat (6) @(posedge mclk_in);
      rst_in <= 1'b0;
      @(posedge mclk_in);
      // Reset values and implemented bits
      rdchk(TEFS_OFF_FLAGS, TEFS_RST_WORD);
      rdchk(TEFS_OFF_SWEVG, TEFS_RST_WORD);
      rdchk(TEFS_OFF_CHMODE, TEFS_RST_WORD);
      rdchk(TEFS_OFF_IRQEN, TEFS_RST_WORD);
      apb(1'b0, 12'h0FC, 32'h0000_0000, r, e);
      chk({31'h0, e}, 32'h0000_0001);
      wr(TEFS_OFF_CHMODE, 32'hFFFF_FFFF);
      rdchk(TEFS_OFF_CHMODE, TEFS_CHMODE_MASK);
      wr(TEFS_OFF_IRQEN, 32'hFFFF_FFFF);
      rdchk(TEFS_OFF_IRQEN, 32'h0000_0047);
      wr(TEFS_OFF_IRQEN, 32'h0000_0000);
      wr(TEFS_OFF_CHMODE, 32'h0000_0000);
      // Overflow update, masking and write-zero clear
      pulse(5'h01);
      rdchk(TEFS_OFF_FLAGS, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(TEFS_OFF_IRQEN, 32'h0000_0001);
      idle(2);
      chk({31'h0, irq}, 32'h0000_0001);
      wr(TEFS_OFF_FLAGS, 32'hFFFF_FFFF);
      rdchk(TEFS_OFF_FLAGS, 32'h0000_0001);
      wr(TEFS_OFF_FLAGS, 32'hFFFF_FFFE);
      rdchk(TEFS_OFF_FLAGS, 32'h0000_0000);
      idle(2);
      chk({31'h0, irq}, 32'h0000_0000);
      // Overflow lands on the clearing write edge; the event must survive
      fork
         wr(TEFS_OFF_FLAGS, 32'h0000_0000);
         begin
            idle(2);
            ev <= 5'h01;
            @(posedge mclk_in);
            ev <= 5'h00;
         end
      join
      idle(3);
      rdchk(TEFS_OFF_FLAGS, 32'h0000_0001);
      wr(TEFS_OFF_FLAGS, 32'h0000_0000);
      // Software update: normal, suppressed, source restricted
      for (int m = 0; m < 3; m++) begin
         wr(TEFS_OFF_CTRL, (m == 0) ? 32'h0 : (m == 1) ? 32'h2 : 32'h4);
         u = n_upd;
         c = n_clr;
         wr(TEFS_OFF_SWEVG, 32'h0000_0001);
         idle(4);
         chk(n_clr - c, 1);
         chk(n_upd - u, (m == 1) ? 0 : 1);
         rdchk(TEFS_OFF_FLAGS, (m == 0) ? 32'h1 : 32'h0);
         rdchk(TEFS_OFF_SWEVG, 32'h0000_0000);
         wr(TEFS_OFF_FLAGS, 32'h0000_0000);
      end
      pulse(5'h01);
      rdchk(TEFS_OFF_FLAGS, 32'h0000_0001);
      wr(TEFS_OFF_CTRL, 32'h0000_0000);
      wr(TEFS_OFF_FLAGS, 32'h0000_0000);
      // Trigger edges: rising only, then both edges in pause mode
      t = n_trg;
      set_trg(1'b1);
      rdchk(TEFS_OFF_FLAGS, 32'h0000_0040);
      wr(TEFS_OFF_FLAGS, 32'h0000_0000);
      set_trg(1'b0);
      rdchk(TEFS_OFF_FLAGS, 32'h0000_0000);
      wr(TEFS_OFF_SLAVE, {29'h0, TEFS_SMC_PAUSE});
      set_trg(1'b1);
      wr(TEFS_OFF_FLAGS, 32'h0000_0000);
      set_trg(1'b0);
      rdchk(TEFS_OFF_FLAGS, 32'h0000_0040);
      chk(n_trg - t, 3);
      wr(TEFS_OFF_SLAVE, 32'h0000_0000);
      wr(TEFS_OFF_FLAGS, 32'h0000_0000);
      // Trigger strobe with its interrupt enabled
      wr(TEFS_OFF_IRQEN, 32'h0000_0040);
      wr(TEFS_OFF_SWEVG, 32'h0000_0040);
      idle(4);
      rdchk(TEFS_OFF_FLAGS, 32'h0000_0040);
      chk({31'h0, irq}, 32'h0000_0001);
      wr(TEFS_OFF_FLAGS, 32'h0000_0000);
      // Reserved strobe bits must not create events
      wr(TEFS_OFF_SWEVG, 32'hFFFF_FFB8);
      idle(4);
      rdchk(TEFS_OFF_FLAGS, 32'h0000_0000);
      // Both channels share one sequence
      for (int ch = 0; ch < 2; ch++) begin
         bp = ch ? TEFS_B_CHB : TEFS_B_CHA;
         ov = ch ? TEFS_B_OVB : TEFS_B_OVA;
         cap_addr = ch ? TEFS_OFF_CAPB : TEFS_OFF_CAPA;
         wr(TEFS_OFF_IRQEN, 32'h1 << bp);
         wr(TEFS_OFF_CHMODE, 32'h0000_0000);
         pulse(ch ? 5'h04 : 5'h02); // Capture ignored in output mode
         rdchk(TEFS_OFF_FLAGS, 32'h0000_0000);
         pulse(ch ? 5'h10 : 5'h08);
         rdchk(TEFS_OFF_FLAGS, 32'h1 << bp);
         chk({31'h0, irq}, 32'h0000_0001);
         wr(TEFS_OFF_CHMODE, 32'h0000_0101);
         wr(TEFS_OFF_FLAGS, 32'h0000_0000);
         pulse(ch ? 5'h10 : 5'h08); // Compare ignored in input mode
         rdchk(TEFS_OFF_FLAGS, 32'h0000_0000);
         cnt <= 16'h1234;
         pulse(ch ? 5'h04 : 5'h02);
         rdchk(TEFS_OFF_FLAGS, 32'h1 << bp);
         cnt <= 16'h5678;
         pulse(ch ? 5'h04 : 5'h02);
         rdchk(TEFS_OFF_FLAGS, (32'h1 << bp) | (32'h1 << ov));
         rdchk(cap_addr, 32'h0000_5678);
         rdchk(TEFS_OFF_FLAGS, 32'h1 << ov);
         wr(TEFS_OFF_FLAGS, 32'h0000_0000);
         cnt <= 16'h0ABC;
         wr(TEFS_OFF_SWEVG, 32'h1 << bp);
         idle(4);
         rdchk(TEFS_OFF_FLAGS, 32'h1 << bp);
         cnt <= 16'h0DEF;
         wr(TEFS_OFF_SWEVG, 32'h1 << bp);
         idle(4);
         rdchk(TEFS_OFF_FLAGS, (32'h1 << bp) | (32'h1 << ov));
         rdchk(cap_addr, 32'h0000_0DEF);
         rdchk(TEFS_OFF_SWEVG, 32'h0000_0000);
         wr(TEFS_OFF_FLAGS, 32'h0000_0000);
         // One compare, two captures and two strobes per channel, none on the other
         chk(n_cha, 5);
         chk(n_chb, ch * 5);
      end
      end_sim();
   end
endmodule
`default_nettype wire
